// ==== design/dcfifo_cfg.svh ====
// constants for the dual-clock 64x18 first-in first-out buffer
// Summary of operation
// RULE1: store input word on push edge when both enables active and input ready high
// RULE2: pop on pop edge only with pop enable and both output enables low, ready high
// RULE3: first word into empty buffer falls through whatever the read controls are
// RULE4: first word appears with output ready on third pop edge after its write
// RULE5: while output ready is low the outputs keep the last word read
// RULE6: output ready changes only on pop edges; low means empty, reads blocked
// RULE7: input ready changes only on push edges; low means full, writes blocked
// RULE8: either output enable high blocks reads and floats all data outputs
// RULE9: reset clears input ready, output ready, half full and sets almost flag
// RULE10: outside logic holds reset over four edges of each side clock
// RULE11: input ready rises on the second push edge after reset release
// RULE12: half full is high when 32 or more words are held
// RULE13: almost flag high when count at most empty offset or at least 64-full offset
// RULE14: both offsets default to 8 when nothing is programmed
// RULE15: offsets are accepted only after reset and before the first write
// RULE16: outside logic keeps program strobe high in reset, lowers it only when allowed
// RULE17: first push edge with strobe low loads low five data bits into both offsets
// RULE18: a second push edge with strobe still low reloads only the full offset
// RULE19: no word is stored while offsets are being programmed
// RULE20: each offset register is five bits wide, values up to 31
// RULE21: storage holds 64 words of 18 bits
// RULE22: side clocks are free running and may be asynchronous or coincident
// RULE23: pointers cross between sides in gray code through two-stage synchronisers
// RULE24: occupancy flags update on edges of either side clock
`ifndef DCFIFO_CFG_SVH
`define DCFIFO_CFG_SVH
`define DCF_DW        18
`define DCF_AW        6
`define DCF_PW        7
`define DCF_DEPTH     8'h40
`define DCF_HALF      8'h20
`define DCF_OFS_W     5
`define DCF_OFS_DEF   5'h08
`define DCF_INIT_LAST 2'h1
`define DCF_PROG_MAX  2'h2
`define DCF_STAGE_D   4
`define DCF_FIRST_MAX 400
`endif

// ==== design/dcfifo_pkg.sv ====
// types shared by the dual-clock buffer
`include "dcfifo_cfg.svh"
package dcfifo_pkg;
  typedef logic [`DCF_DW-1:0]    word_t;
  typedef logic [`DCF_PW-1:0]    ptr_t;
  typedef logic [`DCF_OFS_W-1:0] ofs_t;

  typedef struct packed {
    word_t data;
    logic  en_hi;
    logic  en_lo_n;
    logic  prog_n;
  } push_pins_t;

  typedef struct packed {
    logic pop_n;
    logic oe_a_n;
    logic oe_b_n;
  } pop_pins_t;

  typedef struct packed {
    logic [2:0]            wclk_s;
    logic [2:0]            rclk_s;
    push_pins_t [1:0]      wpin_s;
    pop_pins_t [1:0]       rpin_s;
    word_t [(1<<`DCF_AW)-1:0] mem;
    ptr_t                  wptr;
    ptr_t                  rptr;
    ptr_t                  wg1;
    ptr_t                  wg2;
    ptr_t                  rg1;
    ptr_t                  rg2;
    logic [1:0]            init_cnt;
    logic                  init_done;
    logic [1:0]            prog_cnt;
    logic                  first_wr;
    ofs_t                  ofs_empty;
    ofs_t                  ofs_full;
    logic                  in_rdy;
    logic                  out_rdy;
    logic                  half;
    logic                  afae;
    logic                  oe;
    word_t                 dout;
  } core_state_t;

  function automatic ptr_t bin2gray(input ptr_t b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic ptr_t gray2bin(input ptr_t g);
    ptr_t b;
    b[`DCF_PW-1] = g[`DCF_PW-1];
    for (int i = `DCF_PW-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin
endpackage : dcfifo_pkg

// ==== design/dual_clock_fifo_64x18.sv ====
// dual-clock 64x18 buffer with a four-word staging queue on the push path
`timescale 1ns/1ps
`include "dcfifo_cfg.svh"

module stage_fifo #(
  parameter int W = 18,
  parameter int D = 4
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 in_valid_i,
  output logic                      in_ready_o,
  input  wire logic [W-1:0]         in_data_i,
  output logic                      out_valid_o,
  input  wire logic                 out_ready_i,
  output logic [W-1:0]              out_data_o,
  output logic [$clog2(D+1)-1:0]    count_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D+1);
  typedef struct packed {
    logic [D-1:0][W-1:0] buf_q;
    logic [AW-1:0]       wi;
    logic [AW-1:0]       ri;
    logic [CW-1:0]       cnt;
  } sf_state_t;

  sf_state_t st_reg;
  sf_state_t st_next;
  logic      push;
  logic      pop;

  assign in_ready_o  = (st_reg.cnt != CW'(D));
  assign out_valid_o = (st_reg.cnt != '0);
  assign out_data_o  = st_reg.buf_q[st_reg.ri];
  assign count_o     = st_reg.cnt;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.buf_q[st_reg.wi] = in_data_i;
      st_next.wi = (st_reg.wi == AW'(D-1)) ? '0 : st_reg.wi + 1'b1;
    end
    if (pop) begin
      st_next.ri = (st_reg.ri == AW'(D-1)) ? '0 : st_reg.ri + 1'b1;
    end
    st_next.cnt = st_reg.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : stage_fifo

module dual_clock_fifo_64x18 (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              push_side_clock_i,
  input  wire logic [`DCF_DW-1:0] push_data_in_i,
  input  wire logic              push_enable_active_high_i,
  input  wire logic              push_enable_active_low_n_i,
  input  wire logic              offset_program_strobe_n_i,
  input  wire logic              pop_side_clock_i,
  input  wire logic              pop_enable_n_i,
  input  wire logic              output_enable_a_n_i,
  input  wire logic              output_enable_b_n_i,
  output logic                   input_ready_flag_o,
  output logic                   output_ready_flag_o,
  output logic                   half_full_flag_o,
  output logic                   almost_full_empty_flag_o,
  output logic [`DCF_DW-1:0]     pop_data_out_o,
  output logic                   pop_data_oe_o
);
  localparam int SCW = $clog2(`DCF_STAGE_D+1);

  dcfifo_pkg::core_state_t st_reg;
  dcfifo_pkg::core_state_t st_next;
  dcfifo_pkg::push_pins_t  wpin;
  dcfifo_pkg::pop_pins_t   rpin;
  dcfifo_pkg::word_t       stg_data;
  dcfifo_pkg::ptr_t        mem_used;
  dcfifo_pkg::ptr_t        wbin_sync;
  logic [SCW-1:0]          stg_cnt;
  logic [7:0]              occ;
  logic [7:0]              push_total;
  logic                    wedge;
  logic                    redge;
  logic                    accept;
  logic                    stg_in_ready;
  logic                    stg_valid;
  logic                    drain_ready;
  logic                    rd_req;
  logic                    avail;
  logic                    prog_ok;
  logic                    pop_now;
  logic [7:0]              occ_new;

  // edges of the side clocks, seen only after the two sampling stages
  assign wedge = st_reg.wclk_s[1] && !st_reg.wclk_s[2];
  assign redge = st_reg.rclk_s[1] && !st_reg.rclk_s[2];
  assign wpin  = st_reg.wpin_s[1];
  assign rpin  = st_reg.rpin_s[1];

  // programming window: after reset, before any word is stored
  assign prog_ok = st_reg.init_done && !st_reg.first_wr; // RULE15

  assign accept = wedge && wpin.en_hi && !wpin.en_lo_n // RULE1
                  && st_reg.in_rdy && wpin.prog_n      // RULE19
                  && stg_in_ready;

  // push side sees the pop pointer two push edges late: never overfills
  assign mem_used   = st_reg.wptr - dcfifo_pkg::gray2bin(st_reg.rg2); // RULE23
  assign drain_ready = ({1'b0, mem_used} < `DCF_DEPTH);
  assign push_total = 8'({1'b0, mem_used}) + 8'(stg_cnt) + 8'(accept);

  // pop side sees the push pointer two pop edges late, hence the third edge
  assign wbin_sync = dcfifo_pkg::gray2bin(st_reg.wg2); // RULE23
  assign avail     = (wbin_sync != st_reg.rptr);
  assign rd_req    = !rpin.pop_n && !rpin.oe_a_n && !rpin.oe_b_n; // RULE2

  assign occ = 8'({1'b0, st_reg.wptr - st_reg.rptr}) + 8'(st_reg.out_rdy)
               + 8'(stg_cnt);

  // flags must count the word taken or handed out at this very edge,
  // else they lag until some later edge of either side clock
  assign pop_now = redge && st_reg.out_rdy && rd_req;
  assign occ_new = occ + 8'(accept) - 8'(pop_now);

  stage_fifo #(
    .W (`DCF_DW),
    .D (`DCF_STAGE_D)
  ) u_stage (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (accept),
    .in_ready_o  (stg_in_ready),
    .in_data_i   (wpin.data),
    .out_valid_o (stg_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (stg_data),
    .count_o     (stg_cnt)
  );

  always_comb begin
    st_next = st_reg;
    st_next.wclk_s = {st_reg.wclk_s[1:0], push_side_clock_i}; // RULE22
    st_next.rclk_s = {st_reg.rclk_s[1:0], pop_side_clock_i};
    st_next.wpin_s = {st_reg.wpin_s[0],
                      {push_data_in_i, push_enable_active_high_i,
                       push_enable_active_low_n_i,
                       offset_program_strobe_n_i}};
    st_next.rpin_s = {st_reg.rpin_s[0],
                      {pop_enable_n_i, output_enable_a_n_i,
                       output_enable_b_n_i}};
    st_next.oe = !(rpin.oe_a_n || rpin.oe_b_n); // RULE8

    if (stg_valid && drain_ready) begin
      st_next.mem[st_reg.wptr[`DCF_AW-1:0]] = stg_data; // RULE21
      st_next.wptr = st_reg.wptr + 1'b1;
    end

    if (wedge) begin
      st_next.rg1 = dcfifo_pkg::bin2gray(st_reg.rptr); // RULE23
      st_next.rg2 = st_reg.rg1;
      if (!st_reg.init_done) begin
        if (st_reg.init_cnt == `DCF_INIT_LAST) begin
          st_next.init_done = 1'b1;
          st_next.in_rdy    = 1'b1; // RULE11
        end else begin
          st_next.init_cnt = st_reg.init_cnt + 1'b1;
        end
      end else begin
        st_next.in_rdy = (push_total < `DCF_DEPTH); // RULE7
      end
      if (accept) begin
        st_next.first_wr = 1'b1;
      end
      if (!wpin.prog_n && prog_ok) begin
        if (st_reg.prog_cnt == 2'h0) begin
          st_next.ofs_empty = wpin.data[`DCF_OFS_W-1:0]; // RULE17
          st_next.ofs_full  = wpin.data[`DCF_OFS_W-1:0];
        end else if (st_reg.prog_cnt == 2'h1) begin
          st_next.ofs_full  = wpin.data[`DCF_OFS_W-1:0]; // RULE18
        end
        if (st_reg.prog_cnt != `DCF_PROG_MAX) begin
          st_next.prog_cnt = st_reg.prog_cnt + 1'b1;
        end
      end else if (wpin.prog_n) begin
        st_next.prog_cnt = 2'h0;
      end
    end

    if (redge) begin
      st_next.wg1 = dcfifo_pkg::bin2gray(st_reg.wptr); // RULE23
      st_next.wg2 = st_reg.wg1;
      // an empty output register loads without waiting for a read
      if (!st_reg.out_rdy || rd_req) begin // RULE3
        if (avail) begin
          st_next.dout    = st_reg.mem[st_reg.rptr[`DCF_AW-1:0]]; // RULE4
          st_next.rptr    = st_reg.rptr + 1'b1;
          st_next.out_rdy = 1'b1;
        end else begin
          st_next.out_rdy = 1'b0; // RULE6
        end
      end
    end

    if (wedge || redge) begin
      st_next.half = (occ_new >= `DCF_HALF); // RULE12
      st_next.afae = (occ_new <= 8'(st_reg.ofs_empty)) // RULE13
                     || (occ_new >= (`DCF_DEPTH - 8'(st_reg.ofs_full))); // RULE24
    end
  end

  // reset is sampled by clk_i; the side clocks need not run during it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg           <= '0; // RULE9
      st_reg.afae      <= 1'b1;
      st_reg.ofs_empty <= `DCF_OFS_DEF; // RULE14
      st_reg.ofs_full  <= `DCF_OFS_DEF; // RULE20
    end else begin
      st_reg <= st_next;
    end
  end

  assign input_ready_flag_o       = st_reg.in_rdy;
  assign output_ready_flag_o      = st_reg.out_rdy;
  assign half_full_flag_o         = st_reg.half;
  assign almost_full_empty_flag_o = st_reg.afae;
  assign pop_data_out_o           = st_reg.dout; // RULE5
  assign pop_data_oe_o            = st_reg.oe;

  // checks
  localparam int FIRST_MAX = `DCF_FIRST_MAX;
  // pointer-wide sum, so a wrapping push pointer keeps the total exact
  dcfifo_pkg::ptr_t in_total;
  assign in_total = st_reg.wptr + dcfifo_pkg::ptr_t'(stg_cnt);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_push_edge;
    wedge;
  endsequence
  sequence s_pop_edge;
    redge;
  endsequence
  sequence s_push_blocked;
    s_push_edge ##0 !(wpin.en_hi && !wpin.en_lo_n && st_reg.in_rdy);
  endsequence
  sequence s_prog_edge;
    s_push_edge ##0 (!wpin.prog_n && prog_ok);
  endsequence

  chk_push_gate: assert property ( // RULE1
    s_push_blocked |=> in_total == $past(in_total))
    else $error("word stored without a valid push");
  chk_pop_gate: assert property ( // RULE2
    (s_pop_edge ##0 (st_reg.out_rdy && !rd_req)) |=> $stable(st_reg.rptr))
    else $error("word popped without a valid read");
  chk_fall_thru: assert property ( // RULE3
    (s_pop_edge ##0 (!st_reg.out_rdy && avail)) |=> st_reg.out_rdy)
    else $error("first word did not fall through");
  chk_first_word: assert property ( // RULE4
    $rose(st_reg.first_wr) |-> ##[1:FIRST_MAX] st_reg.out_rdy)
    else $error("first word never reached the output");
  chk_hold_data: assert property ( // RULE5
    (!st_reg.out_rdy && !$past(st_reg.out_rdy)) |-> $stable(st_reg.dout))
    else $error("output word changed while not ready");
  chk_ready_edges: assert property ( // RULE6
    $changed(st_reg.out_rdy) |-> $past(redge))
    else $error("output ready moved off a pop edge");
  chk_in_ready: assert property ( // RULE7
    $changed(st_reg.in_rdy) |-> $past(wedge))
    else $error("input ready moved off a push edge");
  chk_float: assert property ( // RULE8
    (rpin.oe_a_n || rpin.oe_b_n) |=> !st_reg.oe)
    else $error("outputs driven while disabled");
  chk_reset_flags: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> (!st_reg.in_rdy && !st_reg.out_rdy && !st_reg.half // RULE9
               && st_reg.afae))
    else $error("flags wrong after reset");
  chk_half_full: assert property ( // RULE12
    (wedge || redge) |=> st_reg.half == (occ >= `DCF_HALF))
    else $error("half full flag wrong");
  chk_prog_block: assert property ( // RULE19
    (s_push_edge ##0 !wpin.prog_n) |=> in_total == $past(in_total))
    else $error("word stored while programming");
  chk_afae_flag: assert property ( // RULE13
    (wedge || redge) |=> st_reg.afae == ((occ <= 8'(st_reg.ofs_empty))
      || (occ >= `DCF_DEPTH - 8'(st_reg.ofs_full))))
    else $error("almost full or empty flag wrong");
  chk_mem_bound: assert property ( // RULE21
    8'({1'b0, st_reg.wptr - st_reg.rptr}) <= `DCF_DEPTH)
    else $error("memory holds more than its depth");
  chk_first_load: assert property ( // RULE17
    (s_prog_edge ##0 st_reg.prog_cnt == 2'h0)
      |=> st_reg.ofs_empty == st_reg.ofs_full)
    else $error("first program edge did not load both offsets");
  chk_empty_kept: assert property ( // RULE18
    (s_prog_edge ##0 st_reg.prog_cnt == 2'h1) |=> $stable(st_reg.ofs_empty))
    else $error("second program edge changed the empty offset");
  chk_window_shut: assert property ( // RULE15
    st_reg.first_wr |=> ($stable(st_reg.ofs_empty)
                         && $stable(st_reg.ofs_full)))
    else $error("offsets changed after the first write");
endmodule : dual_clock_fifo_64x18

// ==== test/dual_clock_fifo_64x18_test.sv ====
// self-checking bench for the dual-clock 64x18 buffer
`timescale 1ns/1ps
module dual_clock_fifo_64x18_test;
  localparam realtime WP = 80.0;
  localparam realtime RP = 83.0;
  logic              clk_i, rst_i, wclk, rclk, prog_n, acc;
  logic              en_hi, en_lo_n, pop_n, oe_a_n, oe_b_n;
  logic              in_rdy, out_rdy, half, afae, oe;
  dcfifo_pkg::word_t din, dout, last, q[$];
  int                bad_count, n_checks, n, k, ofs_x, ofs_y;
  realtime           t_w, t_r, d;

  side_clocks #(.W_HALF(WP / 2), .R_HALF(RP / 2)) clks (
    .push_clk_o(wclk), .pop_clk_o(rclk));

  dual_clock_fifo_64x18 dut (
    .clk_i(clk_i), .rst_i(rst_i), .push_side_clock_i(wclk),
    .push_data_in_i(din), .push_enable_active_high_i(en_hi),
    .push_enable_active_low_n_i(en_lo_n),
    .offset_program_strobe_n_i(prog_n), .pop_side_clock_i(rclk),
    .pop_enable_n_i(pop_n), .output_enable_a_n_i(oe_a_n),
    .output_enable_b_n_i(oe_b_n), .input_ready_flag_o(in_rdy),
    .output_ready_flag_o(out_rdy), .half_full_flag_o(half),
    .almost_full_empty_flag_o(afae), .pop_data_out_o(dout),
    .pop_data_oe_o(oe));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge wclk) t_w = $realtime;
  always @(posedge rclk) t_r = $realtime;

  task automatic wrap_up();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [17:0] seen, input logic [17:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  function automatic logic afae_exp(input int words, input int x,
                                    input int y);
    return words <= x || words >= 64 - y;
  endfunction : afae_exp

  // inputs move on the first falling system edge after a side clock falls, clear of its rise
  task automatic w_slot();
    @(negedge wclk);
    @(negedge clk_i);
  endtask : w_slot

  task automatic r_slot();
    @(negedge rclk);
    @(negedge clk_i);
  endtask : r_slot

  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end

  initial begin
    din = 18'h00000;
    {en_hi, en_lo_n, prog_n, pop_n, oe_a_n, oe_b_n, acc} = 7'h1E;
    rst_i = 1'b1;
    bad_count = 0;
    n_checks = 0;
    k = $urandom(18);
    repeat (16) @(negedge clk_i);
    repeat (4) @(posedge wclk);
    repeat (4) @(posedge rclk);
    check(18'({in_rdy, out_rdy, half, afae, oe}), 18'h02, "reset flags");
    w_slot();
    rst_i = 1'b0;
    n = 0;
    for (k = 0; k < 6 && in_rdy !== 1'b1; k++) begin
      @(posedge wclk);
      n++;
      repeat (5) @(negedge clk_i);
    end
    check(18'(n), 18'h02, "push edges to input ready");
    ofs_x = $urandom_range(20, 1);
    ofs_y = $urandom_range(20, 1);
    w_slot();
    prog_n = 1'b0;
    {en_hi, en_lo_n} = 2'h2;
    din = {13'($urandom), 5'(ofs_x)};
    w_slot();
    din = {13'($urandom), 5'(ofs_y)};
    w_slot();
    {prog_n, en_hi, en_lo_n} = 3'h5;
    repeat (4) r_slot();
    check(18'(out_rdy), 18'h0, "word stored while programming");
    // place the first write well clear of a pop edge so the count is exact
    for (k = 0; k < 60; k++) begin
      w_slot();
      d = t_w + WP - t_r;
      while (d >= RP) d -= RP;
      if (d > 20.0 && d < 40.0) break;
    end
    check(18'(k < 60), 18'h1, "no slot clear of a pop edge");
    din = 18'h3FFFF;
    {en_hi, en_lo_n} = 2'h2;
    @(posedge wclk);
    q.push_back(din);
    // the push clock rises on a falling system edge: hold past the next rise
    @(posedge clk_i);
    @(negedge clk_i);
    {en_hi, en_lo_n} = 2'h1;
    n = 0;
    for (k = 0; k < 8 && out_rdy !== 1'b1; k++) begin
      @(posedge rclk);
      n++;
      repeat (5) @(negedge clk_i);
    end
    check(18'(n), 18'h03, "pop edges to first word");
    check(dout, 18'h3FFFF, "fall-through word");
    check(18'(oe), 18'h0, "outputs driven while disabled");
    n = 1;
    for (k = 0; k < 400 && in_rdy === 1'b1; k++) begin
      w_slot();
      if (acc) begin
        q.push_back(din);
        n++;
      end
      check(18'(half), 18'(n >= 32), "half full");
      check(18'(afae), 18'(afae_exp(n, ofs_x, ofs_y)), "almost");
      en_hi = $urandom_range(3, 0) != 0;
      en_lo_n = $urandom_range(3, 0) == 0;
      din = 18'($urandom);
      acc = en_hi && !en_lo_n && in_rdy;
    end
    w_slot();
    {en_hi, en_lo_n} = 2'h2;
    w_slot();
    {en_hi, en_lo_n} = 2'h1;
    // the output register holds one word beyond the 64-word array
    check(18'(n), 18'h41, "words taken before full");
    check(18'(in_rdy), 18'h0, "input ready when full");
    pop_n = 1'b0;
    for (k = 0; k < 5; k++) begin
      r_slot();
      check(dout, q[0], "word popped while disabled");
      check(18'({out_rdy, oe}), 18'h2, "ready or enable wrong");
      oe_a_n = k inside {2, 3};
      oe_b_n = k < 2;
    end
    for (k = 0; k < 100 && q.size() > 0; k++) begin
      r_slot();
      last = q.pop_front();
      check(18'({out_rdy, oe}), 18'({q.size() > 0, 1'b1}), "ready");
      check(dout, (q.size() > 0) ? q[0] : last, "popped word");
    end
    check(18'(q.size()), 18'h0, "words left unread");
    repeat (3) r_slot();
    check(dout, last, "output after empty");
    check(18'({out_rdy, half, afae}), 18'h1, "flags when empty");
    wrap_up();
  end
endmodule : dual_clock_fifo_64x18_test

// ==== test/side_clocks.sv ====
// far side of the buffer: free-running push and pop side clocks
`timescale 1ns/1ps
module side_clocks #(
  parameter realtime W_HALF = 40.0,
  parameter realtime R_HALF = 41.5,
  parameter realtime R_SKEW = 13.0
) (
  output logic push_clk_o,
  output logic pop_clk_o
);
  // periods differ, so the pop phase drifts across the push edges
  initial begin
    push_clk_o = 1'b0;
    forever #(W_HALF) push_clk_o = ~push_clk_o;
  end

  initial begin
    pop_clk_o = 1'b0;
    #(R_SKEW);
    forever #(R_HALF) pop_clk_o = ~pop_clk_o;
  end
endmodule : side_clocks
